// ===== dv/pcg_bus_model.sv
// Processor side of unit accesses: issues access pulses to gated units.
// Assumes the bench calls burst() from its own sequence.
`timescale 1ns/10ps
`default_nettype none
module pcg_bus_model
  import pcg_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Unit access request
  output logic acc_valid_out,
  output pcg_pkg::pcg_unit_t acc_unit_out
);
  import pcg_pkg::*;

  initial
  begin
    acc_valid_out = 1'b0;
    acc_unit_out = PCG_U_ADC;
  end

  // Back-to-back accesses starting at one unit index
  task automatic burst(input logic [3:0] first, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_in);
      acc_valid_out <= 1'b1;
      acc_unit_out <= pcg_unit_t'(first + 4'(i));
    end
    @(posedge clk_in);
    acc_valid_out <= 1'b0;
    // Released index shows a changing pattern
    acc_unit_out <= pcg_unit_t'(~(first + 4'(n)));
  endtask
endmodule
`default_nettype wire

// ===== dv/pcg_top_test.sv
// Self-checking bench for the clock gating block.
// Assumes rtl/ on the include path and the access model beside it.
`include "pcg_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pcg_top_test;
  import pcg_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep = 1'b0;
  logic deep = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] reg_rdata_out;
  logic acc_valid;
  pcg_unit_t acc_unit;
  logic acc_fault_out;
  logic acc_ok_out;
  logic [8:0] unit_clk_en_out;
  pcg_rate_t adc_rate_out;
  logic irq_out;
  logic [31:0] rd_q[$];
  logic [1:0] acc_q[$];
  int err_count = 0;
  int comparisons = 0;
  int pos[9] = '{16, 3, 16, 17, 18, 12, 4, 0, 1};
  logic [31:0] r;

  initial
  begin
    forever #10 clk_in = ~clk_in;
  end

  pcg_top pcg_top_i (.clk_in(clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata_out),
    .sleep_in(sleep), .deepsleep_in(deep), .acc_valid_in(acc_valid),
    .acc_unit_in(acc_unit), .acc_fault_out(acc_fault_out),
    .acc_ok_out(acc_ok_out), .unit_clk_en_out(unit_clk_en_out),
    .adc_rate_out(adc_rate_out), .irq_out(irq_out));

  pcg_bus_model pcg_bus_model_i (.clk_in(clk_in),
    .acc_valid_out(acc_valid), .acc_unit_out(acc_unit));

  function automatic logic [8:0] enx(input logic [31:0] b0,
                                     input logic [31:0] b1);
    return {b1[1], b1[0], b1[4], b1[12], b1[18], b1[17], b1[16], b0[3],
            b0[16]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
  endtask

  task automatic chk_en(input logic [31:0] b0, input logic [31:0] b1);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk("unit_clk_en", 32'(enx(b0, b1)), 32'(unit_clk_en_out));
    chk("adc_rate", 32'(b0[9:8]), 32'(adc_rate_out));
  endtask

  task automatic chk_irq(input logic e);
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    chk("irq", 32'(e), 32'(irq_out));
  endtask

  // Results as they appear, against the oldest note
  always @(posedge clk_in)
  begin
    if (rd_d)
      chk("reg_rdata", rd_q.pop_front(), reg_rdata_out);
    if (acc_fault_out | acc_ok_out)
      chk("acc_resp", 32'(acc_q.pop_front()),
          32'({acc_fault_out, acc_ok_out}));
    rd_d <= reg_rd;
  end

  task automatic tally_and_finish;
    if (rd_q.size() != 0 || acc_q.size() != 0)
      err_count++;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(49));
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    foreach (pos[i])
      rd(12'h100 + 12'(i) * 12'h4, 32'h0);
    rd(`PCG_OFS_DSL0, 32'h0);
    rd(`PCG_OFS_CFG, 32'h0);
    rd(12'h1FC, 32'h0);
    chk_en(32'h0, 32'h0);
    wr(`PCG_OFS_RUN0, 32'hFFFF_FFFF);
    wr(`PCG_OFS_RUN1, 32'hFFFF_FFFF);
    rd(`PCG_OFS_RUN0, `PCG_MASK0);
    rd(`PCG_OFS_RUN1, `PCG_MASK1);
    chk_en(`PCG_MASK0, `PCG_MASK1);
    for (int i = 0; i < 9; i++)
    begin
      wr(`PCG_OFS_RUN0, i < 2 ? 32'h1 << pos[i] : 32'h0);
      wr(`PCG_OFS_RUN1, i < 2 ? 32'h0 : 32'h1 << pos[i]);
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk("unit_walk", 32'h1 << i, 32'(unit_clk_en_out));
    end
    for (int k = 0; k < 4; k++)
    begin
      // Every rate encoding, zero as lowest
      wr(`PCG_OFS_RUN0, 32'(k) << 8);
      chk_en(32'(k) << 8, 32'h2);
    end
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom();
      wr(k[0] ? `PCG_OFS_RUN1 : `PCG_OFS_SLP1, r);
      rd(k[0] ? `PCG_OFS_RUN1 : `PCG_OFS_SLP1, r & `PCG_MASK1);
    end
    wr(`PCG_OFS_RUN0, 32'h0001_0000);
    wr(`PCG_OFS_RUN1, 32'h0000_1010);
    wr(`PCG_OFS_ICLR, 32'h3);
    wr(`PCG_OFS_IEN, 32'h1);
    for (int u = 0; u < 10; u++)
      acc_q.push_back(u < 9 && enx(32'h0001_0000, 32'h1010) >> u & 1'b1
                      ? 2'b01 : 2'b10);
    pcg_bus_model_i.burst(4'h0, 10);
    chk_irq(1'b1);
    rd(`PCG_OFS_IST, 32'h1);
    wr(`PCG_OFS_ICLR, 32'h1);
    chk_irq(1'b0);
    rd(`PCG_OFS_ICLR, 32'h0);
    wr(`PCG_OFS_IEN, 32'h0);
    acc_q.push_back(2'b10);
    pcg_bus_model_i.burst(4'h1, 1);
    chk_irq(1'b0);
    rd(`PCG_OFS_IST, 32'h1);
    wr(`PCG_OFS_ICLR, 32'h3);
    wr(`PCG_OFS_RUN0, 32'h0001_0008);
    wr(`PCG_OFS_RUN1, 32'h0000_0001);
    wr(`PCG_OFS_SLP0, 32'h0000_0308);
    wr(`PCG_OFS_SLP1, 32'h0007_0000);
    wr(`PCG_OFS_DSL0, 32'h0001_0100);
    wr(`PCG_OFS_DSL1, 32'h0000_1012);
    sleep <= 1'b1;
    chk_en(32'h0001_0008, 32'h1);
    deep <= 1'b1;
    chk_en(32'h0001_0008, 32'h1);
    wr(`PCG_OFS_CFG, 32'h1);
    chk_en(32'h0001_0100, 32'h1012);
    deep <= 1'b0;
    chk_en(32'h0000_0308, 32'h0007_0000);
    sleep <= 1'b0;
    chk_en(32'h0001_0008, 32'h1);
    rd(`PCG_OFS_CFG, 32'h1);
    rd(`PCG_OFS_IST, 32'h2);
    repeat (4) @(posedge clk_in);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== rtl/pcg_acc_check.sv
// Answers each unit access with a fault or a normal completion.
// Assumes the enable vector is the live registered clock enables.
`include "pcg_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pcg_acc_check
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Access port
  pcg_acc_if.chk acc
);
  logic fault_r;
  logic ok_r;
  logic gated;

  always_comb
  begin
    gated = 1'b1;
    if (acc.unit < pcg_unit_t'(`PCG_NUM_UNITS))
      gated = ~acc.en[acc.unit];
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      fault_r <= 1'b0;
      ok_r <= 1'b0;
    end
    else
    begin
      fault_r <= acc.valid & gated;
      ok_r <= acc.valid & ~gated;
    end
  end

  assign acc.fault = fault_r;
  assign acc.ok = ok_r;

  AST_FAULT_GATED: assert property (@(posedge clk_in) disable iff (srst_in)
    acc.valid && gated |=> acc.fault && !acc.ok)
    else $error("access to gated unit not faulted");
  AST_OK_CLOCKED: assert property (@(posedge clk_in) disable iff (srst_in)
    acc.valid && !gated |=> acc.ok && !acc.fault)
    else $error("access to clocked unit faulted");
  COV_FAULT: cover property (@(posedge clk_in) disable iff (srst_in)
    acc.valid && gated ##1 acc.fault);
endmodule
`default_nettype wire

// ===== rtl/pcg_acc_if.sv
// Carrier between the gating core and the access checker.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface pcg_acc_if;
  logic valid;
  pcg_pkg::pcg_unit_t unit;
  logic [8:0] en;
  logic fault;
  logic ok;
  modport ctl (output valid, output unit, output en,
               input fault, input ok);
  modport chk (input valid, input unit, input en,
               output fault, output ok);
endinterface
`default_nettype wire

// ===== rtl/pcg_defines.svh
// Offsets, field positions, masks and reset values of the gating block.
// Assumes byte addresses on a 12-bit register port.
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_AW 12
`define PCG_OFS_RUN0 12'h100
`define PCG_OFS_SLP0 12'h110
`define PCG_OFS_DSL0 12'h120
`define PCG_OFS_RUN1 12'h104
`define PCG_OFS_SLP1 12'h114
`define PCG_OFS_DSL1 12'h124
`define PCG_OFS_CFG 12'h160
`define PCG_OFS_IST 12'h170
`define PCG_OFS_ICLR 12'h174
`define PCG_OFS_IEN 12'h178

`define PCG_MASK0 32'h0001_0308
`define PCG_MASK1 32'h0007_1013
`define PCG_GATE_RST 32'h0000_0000
`define PCG_CFG_RST 32'h0000_0000
`define PCG_IRQ_RST 32'h0000_0000

`define PCG_B0_ADC 16
`define PCG_B0_RATE_HI 9
`define PCG_B0_RATE_LO 8
`define PCG_B0_WDOG 3
`define PCG_B1_TMRC 18
`define PCG_B1_TMRB 17
`define PCG_B1_TMRA 16
`define PCG_B1_TWI 12
`define PCG_B1_SSI 4
`define PCG_B1_UA1 1
`define PCG_B1_UA0 0

`define PCG_CFG_AUTO 0
`define PCG_CFG_MODE_LO 4
`define PCG_CFG_MASK 32'h0000_0001

`define PCG_IRQ_FAULT 0
`define PCG_IRQ_MODE 1
`define PCG_IRQ_MASK 32'h0000_0003

`define PCG_NUM_UNITS 9

`endif

// ===== rtl/pcg_pkg.sv
// Types shared by the gating block modules.
// Assumes pcg_defines.svh supplies the numeric constants.
package pcg_pkg;

  typedef enum logic [3:0] {
    PCG_U_ADC,
    PCG_U_WDOG,
    PCG_U_TMRA,
    PCG_U_TMRB,
    PCG_U_TMRC,
    PCG_U_TWI,
    PCG_U_SSI,
    PCG_U_UA0,
    PCG_U_UA1
  } pcg_unit_t;

  typedef enum logic [1:0] {
    PCG_MODE_RUN,
    PCG_MODE_SLEEP,
    PCG_MODE_DEEP
  } pcg_mode_t;

  typedef enum logic [1:0] {
    PCG_RATE_125K = 2'h0,
    PCG_RATE_250K = 2'h1,
    PCG_RATE_500K = 2'h2,
    PCG_RATE_1M = 2'h3
  } pcg_rate_t;

  typedef struct packed {
    logic hit;
    logic bank1;
    pcg_mode_t mode;
  } pcg_sel_t;

endpackage

// ===== rtl/pcg_top.sv
// Peripheral clock gating control with run, sleep and deep-sleep sets.
// Assumes a single-cycle register port and synchronous mode inputs.
`include "pcg_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [`PCG_AW-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Power mode
  input wire logic sleep_in,
  input wire logic deepsleep_in,
  // Unit access check
  input wire logic acc_valid_in,
  input wire pcg_pkg::pcg_unit_t acc_unit_in,
  output logic acc_fault_out,
  output logic acc_ok_out,
  // Gated outputs
  output logic [8:0] unit_clk_en_out,
  output pcg_pkg::pcg_rate_t adc_rate_out,
  output logic irq_out
);
  import pcg_pkg::*;

  logic [31:0] bank0_r [3];
  logic [31:0] bank1_r [3];
  logic [31:0] cfg_r;
  logic [31:0] irq_stat_r;
  logic [31:0] irq_en_r;
  logic [31:0] rdata_r;
  logic [8:0] clk_en_r;
  pcg_rate_t rate_r;
  pcg_mode_t mode_r;
  pcg_mode_t mode_nxt;
  logic irq_r;
  logic [31:0] irq_stat_nxt;
  logic [31:0] irq_set;
  logic [31:0] irq_clr;
  pcg_sel_t wsel;
  pcg_sel_t rsel;

  pcg_acc_if acc ();

  // Register decode shared by read and write paths
  function automatic pcg_sel_t pcg_decode(input logic [`PCG_AW-1:0] a);
    pcg_sel_t s;
    s = '{hit: 1'b1, bank1: 1'b0, mode: PCG_MODE_RUN};
    case (a)
      `PCG_OFS_RUN0: s.mode = PCG_MODE_RUN;
      `PCG_OFS_SLP0: s.mode = PCG_MODE_SLEEP;
      `PCG_OFS_DSL0: s.mode = PCG_MODE_DEEP;
      `PCG_OFS_RUN1:
      begin
        s.bank1 = 1'b1;
        s.mode = PCG_MODE_RUN;
      end
      `PCG_OFS_SLP1:
      begin
        s.bank1 = 1'b1;
        s.mode = PCG_MODE_SLEEP;
      end
      `PCG_OFS_DSL1:
      begin
        s.bank1 = 1'b1;
        s.mode = PCG_MODE_DEEP;
      end
      default: s.hit = 1'b0;
    endcase
    return s;
  endfunction

  // Unit enables from one bank pair
  function automatic logic [8:0] pcg_unit_en(input logic [31:0] b0,
                                             input logic [31:0] b1);
    logic [8:0] e;
    e = 9'h000;
    e[PCG_U_ADC] = b0[`PCG_B0_ADC];
    e[PCG_U_WDOG] = b0[`PCG_B0_WDOG];
    e[PCG_U_TMRA] = b1[`PCG_B1_TMRA];
    e[PCG_U_TMRB] = b1[`PCG_B1_TMRB];
    e[PCG_U_TMRC] = b1[`PCG_B1_TMRC];
    e[PCG_U_TWI] = b1[`PCG_B1_TWI];
    e[PCG_U_SSI] = b1[`PCG_B1_SSI];
    e[PCG_U_UA0] = b1[`PCG_B1_UA0];
    e[PCG_U_UA1] = b1[`PCG_B1_UA1];
    return e;
  endfunction

  assign wsel = pcg_decode(reg_addr_in);
  assign rsel = pcg_decode(reg_addr_in);

  // One register set per power mode
  genvar m;
  generate
    for (m = 0; m < 3; m++)
    begin : g_mode
      always_ff @(posedge clk_in)
      begin
        if (srst_in)
        begin
          bank0_r[m] <= `PCG_GATE_RST;
          bank1_r[m] <= `PCG_GATE_RST;
        end
        else if (reg_wr_in && wsel.hit && wsel.mode == pcg_mode_t'(m))
        begin
          // Spare and reserved positions never store
          if (wsel.bank1)
            bank1_r[m] <= reg_wdata_in & `PCG_MASK1;
          else
            bank0_r[m] <= reg_wdata_in & `PCG_MASK0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cfg_r <= `PCG_CFG_RST;
    else if (reg_wr_in && reg_addr_in == `PCG_OFS_CFG)
      cfg_r <= reg_wdata_in & `PCG_CFG_MASK;
  end

  // Mode selection: low-power sets only under auto-gating
  always_comb
  begin
    mode_nxt = PCG_MODE_RUN;
    if (cfg_r[`PCG_CFG_AUTO])
    begin
      if (deepsleep_in)
        mode_nxt = PCG_MODE_DEEP;
      else if (sleep_in)
        mode_nxt = PCG_MODE_SLEEP;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mode_r <= PCG_MODE_RUN;
      clk_en_r <= 9'h000;
      rate_r <= PCG_RATE_125K;
    end
    else
    begin
      mode_r <= mode_nxt;
      clk_en_r <= pcg_unit_en(bank0_r[mode_nxt], bank1_r[mode_nxt]);
      // Zero encoding passes through as the lowest rate
      rate_r <= pcg_rate_t'(bank0_r[mode_nxt][`PCG_B0_RATE_HI:
                                              `PCG_B0_RATE_LO]);
    end
  end

  // Access check
  assign acc.valid = acc_valid_in;
  assign acc.unit = acc_unit_in;
  assign acc.en = clk_en_r;

  pcg_acc_check u_chk (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .acc(acc.chk)
  );

  // Interrupt status: set wins over clear
  always_comb
  begin
    irq_set = 32'h0000_0000;
    irq_set[`PCG_IRQ_FAULT] = acc.fault;
    irq_set[`PCG_IRQ_MODE] = (mode_nxt != mode_r);
    irq_clr = 32'h0000_0000;
    if (reg_wr_in && reg_addr_in == `PCG_OFS_ICLR)
      irq_clr = reg_wdata_in & `PCG_IRQ_MASK;
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_stat_r <= `PCG_IRQ_RST;
    else
      irq_stat_r <= irq_stat_nxt;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_en_r <= `PCG_IRQ_RST;
    else if (reg_wr_in && reg_addr_in == `PCG_OFS_IEN)
      irq_en_r <= reg_wdata_in & `PCG_IRQ_MASK;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_r <= 1'b0;
    else if (reg_wr_in && reg_addr_in == `PCG_OFS_IEN)
      irq_r <= |(irq_stat_nxt & reg_wdata_in & `PCG_IRQ_MASK);
    else
      irq_r <= |(irq_stat_nxt & irq_en_r);
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd_in)
    begin
      if (rsel.hit)
        rdata_r <= rsel.bank1 ? bank1_r[rsel.mode] : bank0_r[rsel.mode];
      else if (reg_addr_in == `PCG_OFS_CFG)
        rdata_r <= cfg_r | (32'(mode_r) << `PCG_CFG_MODE_LO);
      else if (reg_addr_in == `PCG_OFS_IST)
        rdata_r <= irq_stat_r;
      else if (reg_addr_in == `PCG_OFS_IEN)
        rdata_r <= irq_en_r;
      else
        rdata_r <= 32'h0000_0000;
    end
    else
      rdata_r <= 32'h0000_0000;
  end

  assign reg_rdata_out = rdata_r;
  assign unit_clk_en_out = clk_en_r;
  assign adc_rate_out = rate_r;
  assign irq_out = irq_r;
  assign acc_fault_out = acc.fault;
  assign acc_ok_out = acc.ok;

  // Checks
  AST_GATE_RESET: assert property (@(posedge clk_in)
    srst_in |=> clk_en_r == 9'h000 && bank1_r[0] == 32'h0000_0000)
    else $error("gating not cleared by reset");

  AST_RESERVED_ZERO: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (bank0_r[0] & ~`PCG_MASK0) == 32'h0 &&
    (bank1_r[2] & ~`PCG_MASK1) == 32'h0)
    else $error("reserved gating bit stored");

  AST_RUN_UART_EN: assert property (@(posedge clk_in)
    disable iff (srst_in)
    reg_wr_in && reg_addr_in == `PCG_OFS_RUN1 && reg_wdata_in[0] &&
    !cfg_r[`PCG_CFG_AUTO] ##1 !cfg_r[`PCG_CFG_AUTO] && !reg_wr_in
    |=> unit_clk_en_out[PCG_U_UA0])
    else $error("run set write did not enable first async port");

  AST_AUTO_OFF_RUN: assert property (@(posedge clk_in)
    disable iff (srst_in)
    !cfg_r[`PCG_CFG_AUTO] && (sleep_in || deepsleep_in)
    |=> clk_en_r == pcg_unit_en($past(bank0_r[0]), $past(bank1_r[0])))
    else $error("low-power set used without auto-gating");

  AST_DEEP_SET: assert property (@(posedge clk_in)
    disable iff (srst_in)
    cfg_r[`PCG_CFG_AUTO] && deepsleep_in
    |=> mode_r == PCG_MODE_DEEP &&
        clk_en_r == pcg_unit_en($past(bank0_r[2]), $past(bank1_r[2])))
    else $error("deep-sleep set not applied");

  AST_SLEEP_SET: assert property (@(posedge clk_in)
    disable iff (srst_in)
    cfg_r[`PCG_CFG_AUTO] && sleep_in && !deepsleep_in
    |=> mode_r == PCG_MODE_SLEEP &&
        adc_rate_out == $past(bank0_r[1][9:8]))
    else $error("sleep set not applied");

  AST_READ_BACK: assert property (@(posedge clk_in)
    disable iff (srst_in)
    reg_rd_in && reg_addr_in == `PCG_OFS_DSL0
    |=> reg_rdata_out == $past(bank0_r[2]) &&
        reg_rdata_out[15:10] == 6'h00)
    else $error("gating register read back wrong");

  AST_FAULT_IRQ: assert property (@(posedge clk_in)
    disable iff (srst_in)
    acc_fault_out && irq_en_r[`PCG_IRQ_FAULT] |=> irq_out ##1 irq_stat_r[0])
    else $error("fault did not raise interrupt");

  AST_ADC_GATE: assert property (@(posedge clk_in)
    disable iff (srst_in)
    mode_nxt == PCG_MODE_RUN && !bank0_r[0][16]
    |=> !unit_clk_en_out[PCG_U_ADC])
    else $error("converter clocked while gated");

  AST_TWI_RUN: assert property (@(posedge clk_in)
    disable iff (srst_in)
    mode_nxt == PCG_MODE_RUN
    |=> unit_clk_en_out[PCG_U_TWI] == $past(bank1_r[0][`PCG_B1_TWI]))
    else $error("two-wire enable does not follow run set");

  AST_SSI_RUN: assert property (@(posedge clk_in)
    disable iff (srst_in)
    mode_nxt == PCG_MODE_RUN
    |=> unit_clk_en_out[PCG_U_SSI] == $past(bank1_r[0][`PCG_B1_SSI]))
    else $error("sync serial enable does not follow run set");

  AST_SPARE_ZERO: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (bank0_r[1] & ~`PCG_MASK0) == 32'h0 &&
    (bank1_r[1] & ~`PCG_MASK1) == 32'h0)
    else $error("spare gating bit stored");

  COV_DEEP: cover property (@(posedge clk_in) disable iff (srst_in)
    mode_r == PCG_MODE_RUN ##1 mode_r == PCG_MODE_DEEP);
  COV_FAULT_IRQ: cover property (@(posedge clk_in) disable iff (srst_in)
    acc_fault_out ##1 irq_out);
  COV_RATE: cover property (@(posedge clk_in) disable iff (srst_in)
    adc_rate_out == PCG_RATE_1M);
  COV_DEEP_TO_SLEEP: cover property (@(posedge clk_in) disable iff (srst_in)
    mode_r == PCG_MODE_DEEP ##1 mode_r == PCG_MODE_SLEEP);
endmodule
`default_nettype wire
